// [shared/cmd_port_pkg.sv]
// Purpose: Constants and types for the ASCII command port.
// Assumes: Bytes arrive as 8-bit words with valid only and leave with valid/ready.
// Notes: Character codes and sizes are named once here.
// Functional notes
// - Asterisk anytime restarts parser at the address field.
// - Frame: addr_cmd_param_value then terminator.
// - Address A..Z; only A is answered.
// - Command a..z; only d r u w implemented.
// - Fields are decimal 0..65535, no leading zeros.
// - Negatives travel as unsigned 16-bit values.
// - Frames and responses end with 0x15.
// - Underscore separates all fields.
// - Every received frame character is echoed.
// - Ack: period ok, question unknown, hash fault.
// - Execute after terminator, then send period.
// - Requests append decimal value and terminator.
// - d_1 starts streaming, d_0 stops it.
// - Commands execute at once, control keeps running.
// - Working data immediate, config waits for update.
package cmd_port_pkg;
	localparam logic [7:0] CH_SYNC = 8'h2a;
	localparam logic [7:0] CH_SEP = 8'h5f;
	localparam logic [7:0] CH_END = 8'h15;
	localparam logic [7:0] CH_OK = 8'h2e;
	localparam logic [7:0] CH_UNK = 8'h3f;
	localparam logic [7:0] CH_FAULT = 8'h23;
	localparam logic [7:0] CH_ADDR = 8'h41;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CMD_DEBUG = 8'h64;
	localparam logic [7:0] CMD_READ = 8'h72;
	localparam logic [7:0] CMD_UPDATE = 8'h75;
	localparam logic [7:0] CMD_WRITE = 8'h77;
	localparam int DIGITS = 5;
	localparam int BUF_DEPTH = 2;
	typedef enum logic [1:0] {ACK_OK, ACK_UNK, ACK_FAULT} ack_type;
endpackage

// [shared/byte_if.sv]
`timescale 1ns/10ps
// Purpose: Byte stream with valid and ready between internal blocks.
// Assumes: Transfer happens when valid and ready are high together.
// Notes: One word moves per clock at most.
interface byte_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface

// [verilog/byte_buffer.sv]
`timescale 1ns/10ps
// Purpose: Two-entry byte buffer in the transmit path.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Full refuses input, so a stalled receiver loses no byte.
module byte_buffer
	import cmd_port_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// Streams
	byte_if.sink in_s,
	byte_if.source out_s
);
	logic [7:0] mem_r [BUF_DEPTH];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] count_r;
	logic push;
	logic pop;

	assign in_s.ready = (count_r != 2'(BUF_DEPTH));
	assign out_s.valid = (count_r != 2'h0);
	assign out_s.data = mem_r[rd_ptr_r];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r <= count_r + 2'(push) - 2'(pop);
		end
	end

	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			mem_r[0] <= 8'h00;
			mem_r[1] <= 8'h00;
		end
		else if (push)
			mem_r[wr_ptr_r] <= in_s.data;
	end

	a_buf_no_overflow: assert property (@(posedge CLOCK) disable iff (RESET)
		count_r <= 2'(BUF_DEPTH))
		else $error("buffer count exceeds depth");
	c_buf_full: cover property (@(posedge CLOCK) disable iff (RESET)
		count_r == 2'(BUF_DEPTH));
endmodule

// [verilog/cmd_port.sv]
`timescale 1ns/10ps
// Purpose: ASCII command interpreter with echo, ack and response.
// Assumes: A UART outside turns line traffic into bytes.
// Notes: Commands reach the application through a one-cycle strobe.
module cmd_port
	import cmd_port_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// Received bytes
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	// Transmitted bytes
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	input wire logic TX_READY,
	// Command to the application
	output logic CMD_STROBE,
	output logic [7:0] CMD_CODE,
	output logic [15:0] CMD_PARAM,
	output logic [15:0] CMD_VALUE,
	input wire logic [15:0] REPLY_VALUE,
	input wire logic CMD_FAULT,
	// Debug stream
	output logic DEBUG_ACTIVE,
	input wire logic DEBUG_VALID,
	input wire logic [15:0] DEBUG_VALUE,
	output logic DEBUG_TAKEN
);
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_SEP1, S_CMD, S_SEP2, S_PARAM, S_VALUE,
		S_EXEC, S_ACK, S_DIGIT, S_TERM, S_SKIP
	} state_type;

	state_type state_r;
	logic [7:0] cmd_r;
	logic [16:0] param_r;
	logic [16:0] value_r;
	logic bad_r;
	logic first_r;
	ack_type ack_r;
	logic [15:0] out_val_r;
	logic [2:0] dig_r;
	logic seen_r;
	logic debug_r;
	logic strobe_r;
	logic [7:0] tx_byte;
	logic tx_push;
	logic rx_take;
	logic echo_now;
	logic in_frame;

	byte_if tx_in();
	byte_if tx_out();

	function automatic logic is_digit(input logic [7:0] c);
		return c >= CH_ZERO && c <= 8'h39;
	endfunction

	// Accumulate a decimal digit; bit 16 flags overflow past 65535.
	function automatic logic [16:0] add_digit(input logic [16:0] acc,
		input logic [7:0] c);
		logic [20:0] t;
		t = 21'(acc[15:0]) * 21'd10 + 21'(c - CH_ZERO);
		return {acc[16] || (t > 21'd65535), t[15:0]};
	endfunction

	// Count of decimal digits in a value, never less than one.
	function automatic logic [2:0] num_digits(input logic [15:0] v);
		logic [2:0] n;
		logic [16:0] p;
		n = 3'h1;
		p = 17'd10;
		for (int i = 0; i < 4; i++)
		begin
			if (17'(v) >= p)
				n = n + 3'h1;
			p = 17'(p * 17'd10);
		end
		return n;
	endfunction

	assign in_frame = state_r inside {S_ADDR, S_SEP1, S_CMD, S_SEP2,
		S_PARAM, S_VALUE, S_SKIP};
	// A byte is only taken when the echo slot is free; the master
	// waits for each echo, so no byte is offered while it is busy.
	assign rx_take = RX_VALID && tx_in.ready;
	assign echo_now = rx_take && (in_frame || RX_DATA == CH_SYNC);

	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			state_r <= S_IDLE;
			cmd_r <= 8'h00;
			param_r <= 17'h0;
			value_r <= 17'h0;
			bad_r <= 1'b0;
			first_r <= 1'b0;
			seen_r <= 1'b0;
			ack_r <= ACK_OK;
			out_val_r <= 16'h0;
			dig_r <= 3'h0;
			debug_r <= 1'b0;
			strobe_r <= 1'b0;
		end
		else
		begin
			strobe_r <= 1'b0;
			if (rx_take && RX_DATA == CH_SYNC)
			begin
				state_r <= S_ADDR;
				bad_r <= 1'b0;
			end
			else if (rx_take)
			begin
				unique case (state_r)
				S_ADDR:
				begin
					// Other addresses are ignored until the next sync.
					state_r <= (RX_DATA == CH_ADDR) ? S_SEP1 : S_SKIP;
				end
				S_SEP1, S_SEP2:
				begin
					if (RX_DATA != CH_SEP)
						bad_r <= 1'b1;
					state_r <= (state_r == S_SEP1) ? S_CMD : S_PARAM;
					param_r <= 17'h0;
					value_r <= 17'h0;
					first_r <= 1'b1;
					seen_r <= 1'b0;
				end
				S_CMD:
				begin
					cmd_r <= RX_DATA;
					if (!(RX_DATA inside {CMD_DEBUG, CMD_READ, CMD_UPDATE,
						CMD_WRITE}))
						bad_r <= 1'b1;
					state_r <= S_SEP2;
				end
				S_PARAM, S_VALUE:
				begin
					if (is_digit(RX_DATA))
					begin
						// A leading zero followed by more digits is malformed.
						if (seen_r && !first_r && param_r == 17'h0 &&
							state_r == S_PARAM)
							bad_r <= 1'b1;
						if (state_r == S_PARAM)
							param_r <= add_digit(param_r, RX_DATA);
						else
							value_r <= add_digit(value_r, RX_DATA);
						if (!first_r && ((state_r == S_PARAM) ?
							param_r == 17'h0 : value_r == 17'h0))
							bad_r <= 1'b1;
						first_r <= 1'b0;
						seen_r <= 1'b1;
					end
					else if (RX_DATA == CH_SEP && state_r == S_PARAM)
					begin
						if (first_r)
							bad_r <= 1'b1;
						first_r <= 1'b1;
						state_r <= S_VALUE;
					end
					else if (RX_DATA == CH_END && state_r == S_VALUE)
					begin
						if (first_r)
							bad_r <= 1'b1;
						state_r <= S_EXEC;
					end
					else
						bad_r <= 1'b1;
				end
				S_SKIP:
				begin
					if (RX_DATA == CH_END)
						state_r <= S_IDLE;
				end
				default:
				begin
					state_r <= S_IDLE;
				end
				endcase
			end
			else
			begin
				unique case (state_r)
				S_EXEC:
				begin
					// Execution takes one cycle; control runs on in parallel.
					if (bad_r || param_r[16] || value_r[16])
						ack_r <= ACK_UNK;
					else
					begin
						strobe_r <= 1'b1;
						ack_r <= ACK_OK;
						if (cmd_r == CMD_DEBUG)
							debug_r <= (param_r[15:0] != 16'h0);
					end
					state_r <= S_ACK;
				end
				S_ACK:
				begin
					if (tx_push)
					begin
						state_r <= (ack_r == ACK_OK && cmd_r == CMD_READ) ?
							S_DIGIT : S_IDLE;
						out_val_r <= REPLY_VALUE;
						dig_r <= 3'h0;
					end
					else if (strobe_r && CMD_FAULT)
						ack_r <= ACK_FAULT;
				end
				S_DIGIT:
				begin
					// Stop after the last significant digit of the value.
					if (tx_push &&
						dig_r == num_digits(out_val_r) - 3'h1)
						state_r <= S_TERM;
					if (tx_push)
						dig_r <= dig_r + 3'h1;
				end
				S_TERM:
				begin
					if (tx_push)
						state_r <= S_IDLE;
				end
				default:
				begin
				end
				endcase
				// Debug streaming picks up an idle slot as the value's digits, without leading zeros.
				if (state_r == S_IDLE && debug_r && DEBUG_VALID &&
					!RX_VALID && tx_in.ready)
				begin
					out_val_r <= DEBUG_VALUE;
					dig_r <= 3'h0;
					state_r <= S_DIGIT;
				end
			end
		end
	end

	// Digits of the reply, most significant first, without leading zeros.
	always_comb
	begin
		logic [15:0] v;
		logic [2:0] n;
		logic [15:0] p;
		v = out_val_r;
		n = num_digits(out_val_r);
		p = 16'd1;
		tx_byte = 8'h00;
		unique case (state_r)
		S_ACK:
			tx_byte = (ack_r == ACK_OK) ? CH_OK :
				(ack_r == ACK_UNK) ? CH_UNK : CH_FAULT;
		S_DIGIT:
		begin
			p = 16'd1;
			for (int i = 0; i < 4; i++)
				if (3'(i) < n - dig_r - 3'h1)
					p = 16'(p * 16'd10);
			tx_byte = CH_ZERO + 8'((v / p) % 16'd10);
		end
		S_TERM:
			tx_byte = CH_END;
		default:
			tx_byte = RX_DATA;
		endcase
	end

	assign tx_push = tx_in.ready && !echo_now &&
		state_r inside {S_ACK, S_DIGIT, S_TERM} &&
		!(state_r == S_ACK && strobe_r);
	assign tx_in.valid = echo_now || tx_push;
	assign tx_in.data = echo_now ? RX_DATA : tx_byte;

	byte_buffer u_buf (
		.CLOCK(CLOCK),
		.RESET(RESET),
		.in_s(tx_in),
		.out_s(tx_out)
	);

	assign TX_VALID = tx_out.valid;
	assign TX_DATA = tx_out.data;
	assign tx_out.ready = TX_READY;
	assign CMD_STROBE = strobe_r;
	assign CMD_CODE = cmd_r;
	assign CMD_PARAM = param_r[15:0];
	assign CMD_VALUE = value_r[15:0];
	assign DEBUG_ACTIVE = debug_r;
	assign DEBUG_TAKEN = state_r == S_IDLE && debug_r && DEBUG_VALID &&
		!RX_VALID && tx_in.ready;

	a_sync_resets: assert property (@(posedge CLOCK) disable iff (RESET)
		rx_take && RX_DATA == CH_SYNC |=> state_r == S_ADDR)
		else $error("sync did not restart parser");
	a_idle_no_echo: assert property (@(posedge CLOCK) disable iff (RESET)
		state_r == S_IDLE && RX_DATA != CH_SYNC |-> !echo_now)
		else $error("idle byte was echoed");
	a_echo_data: assert property (@(posedge CLOCK) disable iff (RESET)
		echo_now |-> tx_in.valid && tx_in.data == RX_DATA)
		else $error("echo byte wrong");
	a_ack_after_exec: assert property (@(posedge CLOCK) disable iff (RESET)
		state_r == S_EXEC && !rx_take |=> state_r == S_ACK)
		else $error("no ack after terminator");
	a_strobe_valid: assert property (@(posedge CLOCK) disable iff (RESET)
		CMD_STROBE |-> !$past(bad_r))
		else $error("bad frame executed");
	a_term_closes: assert property (@(posedge CLOCK) disable iff (RESET)
		state_r == S_TERM && tx_push |-> tx_in.data == CH_END)
		else $error("reply terminator wrong");
	a_debug_on: assert property (@(posedge CLOCK) disable iff (RESET)
		CMD_STROBE && cmd_r == CMD_DEBUG |-> DEBUG_ACTIVE ==
		(CMD_PARAM != 16'h0))
		else $error("debug mode not set");
	a_wrong_addr: assert property (@(posedge CLOCK) disable iff (RESET)
		state_r == S_ADDR && rx_take && RX_DATA != CH_ADDR &&
		RX_DATA != CH_SYNC |=> state_r == S_SKIP)
		else $error("foreign address accepted");
	c_read_done: cover property (@(posedge CLOCK) disable iff (RESET)
		state_r == S_TERM && tx_push);
	c_write_ok: cover property (@(posedge CLOCK) disable iff (RESET)
		CMD_STROBE && CMD_CODE == CMD_WRITE);
	c_unknown: cover property (@(posedge CLOCK) disable iff (RESET)
		state_r == S_ACK && ack_r == ACK_UNK);
	c_debug: cover property (@(posedge CLOCK) disable iff (RESET)
		DEBUG_TAKEN);
endmodule

// [tb/host_model.sv]
`timescale 1ns/10ps
// Purpose: Host side of the command port: sends bytes, accepts replies.
// Assumes: The bench calls put once per byte and then waits for the echo.
// Notes: Slow mode takes a reply byte only one cycle in four.
module host_model
(
	// Clock
	input wire logic CLOCK,
	// Link
	input wire logic slow,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic tx_ready
);
	logic [1:0] cnt_r;
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
		cnt_r = 2'h0;
	end
	always @(negedge CLOCK)
	begin
		cnt_r <= cnt_r + 2'h1;
		tx_ready <= !slow || cnt_r == 2'h0;
	end
	// A released data line shows the inverse, so stale bytes never match.
	task put(input logic [7:0] b);
		@(negedge CLOCK);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(negedge CLOCK);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask
endmodule

// [tb/ascii_echo_command_port_bench.sv]
`timescale 1ns/10ps
// Purpose: Self-checking bench for the command port.
// Assumes: Expected bytes are queued before the design can send them.
// Notes: A monitor pops the oldest expected byte at each transmit.
module ascii_echo_command_port_bench;
	import cmd_port_pkg::*;
	logic clock, reset, slow, rx_valid, tx_valid, tx_ready, strobe, fault;
	logic active, dbg_valid, dbg_taken;
	logic [7:0] rx_data, tx_data, code;
	logic [15:0] param, value, reply, dbg_value, p, v;
	int n_errors, samples_checked, seed, i;
	logic [7:0] exp_q[$];
	logic [39:0] cmd_q[$];
	cmd_port uut (.CLOCK(clock), .RESET(reset), .RX_VALID(rx_valid),
		.RX_DATA(rx_data), .TX_VALID(tx_valid), .TX_DATA(tx_data),
		.TX_READY(tx_ready), .CMD_STROBE(strobe), .CMD_CODE(code),
		.CMD_PARAM(param), .CMD_VALUE(value), .REPLY_VALUE(reply),
		.CMD_FAULT(fault), .DEBUG_ACTIVE(active), .DEBUG_VALID(dbg_valid),
		.DEBUG_VALUE(dbg_value), .DEBUG_TAKEN(dbg_taken));
	host_model host (.CLOCK(clock), .slow(slow), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_ready(tx_ready));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task check(input logic [39:0] exp, input logic [39:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// An unexpected byte or strobe meets an empty queue and fails.
	// Outputs settle after the rising edge and the host moves ready on
	// the falling one, so look just after it at what the next rising
	// edge will take.
	always @(negedge clock)
	begin
		#1;
		if (tx_valid && tx_ready)
			check(exp_q.size() ? exp_q.pop_front() : 'x, tx_data);
		if (strobe)
			check(cmd_q.size() ? cmd_q.pop_front() : 'x, {code, param, value});
	end
	task drain;
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 3000)
		begin
			@(negedge clock);
			k++;
		end
		check(0, exp_q.size());
	endtask
	task note(input string s);
		for (int j = 0; j < s.len(); j++)
			exp_q.push_back(s[j]);
	endtask
	// Each byte waits for its own echo before the next goes out.
	task send(input string s);
		for (int j = 0; j < s.len(); j++)
		begin
			exp_q.push_back(s[j]);
			host.put(s[j]);
			drain();
		end
	endtask
	task frame(input string body, input logic [7:0] ack, input logic [39:0] cmd);
		if (ack == CH_OK || ack == CH_FAULT)
			cmd_q.push_back(cmd);
		send($sformatf("*%s%c", body, CH_END));
		if (ack != 8'h00)
			exp_q.push_back(ack);
		if (ack == CH_OK && cmd[39:32] == CMD_READ)
			note($sformatf("%0d%c", reply, CH_END));
		drain();
	endtask
	// The value is offered until the edge that takes it, then withdrawn,
	// so that it goes out exactly once.
	task stream(input logic [15:0] d);
		int k;
		note($sformatf("%0d%c", d, CH_END));
		dbg_value = d;
		dbg_valid = 1'b1;
		k = 0;
		#1;
		while (dbg_taken !== 1'b1 && k < 100)
		begin
			@(negedge clock);
			#1;
			k++;
		end
		@(negedge clock);
		dbg_valid = 1'b0;
		drain();
	endtask
	initial
	begin
		#2000000;
		n_errors++;
		finish_test;
	end
	initial
	begin
		seed = 98;
		reset = 1'b1;
		slow = 1'b0;
		fault = 1'b0;
		reply = 16'h0000;
		dbg_valid = 1'b0;
		dbg_value = 16'h0000;
		n_errors = 0;
		samples_checked = 0;
		repeat (8) @(negedge clock);
		reset = 1'b0;
		host.put("x");
		repeat (6) @(negedge clock);
		for (i = 0; i < 6; i++)
		begin
			slow = i[0];
			p = 16'($random(seed));
			v = 16'($random(seed));
			reply = 16'($random(seed));
			frame($sformatf("A_r_%0d_%0d", p, v), CH_OK, {CMD_READ, p, v});
		end
		frame("A_w_0_65535", CH_OK, {CMD_WRITE, 16'h0000, 16'hffff});
		fault = 1'b1;
		frame("A_u_0_0", CH_FAULT, {CMD_UPDATE, 32'h0});
		fault = 1'b0;
		frame("A_x_0_0", CH_UNK, 40'h0);
		frame("A_w_01_0", CH_UNK, 40'h0);
		frame("A_w_65536_0", CH_UNK, 40'h0);
		frame("B_r_0_0", 8'h00, 40'h0);
		send("*A_w_7");
		frame("A_w_3_4", CH_OK, {CMD_WRITE, 16'h0003, 16'h0004});
		frame("A_d_1_0", CH_OK, {CMD_DEBUG, 16'h0001, 16'h0000});
		check(1, active);
		repeat (3) stream(16'($random(seed)));
		frame("A_d_0_0", CH_OK, {CMD_DEBUG, 32'h0});
		check(0, active);
		dbg_valid = 1'b1;
		repeat (20) @(negedge clock);
		dbg_valid = 1'b0;
		finish_test;
	end
endmodule
